// ### verilog/qsm_pkg.sv
// Package for the quad-short multiply-accumulate datapath.
// Assumes one clock domain and an APB slave front end in qsm_core.
`default_nettype none

package qsm_pkg;

	// Register byte offsets, one aligned 32-bit word each
	localparam logic [7:0] QSM_OPA_LO = 8'h00; // First operand, lanes 1:0
	localparam logic [7:0] QSM_OPA_HI = 8'h04; // First operand, lanes 3:2
	localparam logic [7:0] QSM_OPB_LO = 8'h08; // Second operand, lanes 1:0
	localparam logic [7:0] QSM_OPB_HI = 8'h0C; // Second operand, lanes 3:2
	localparam logic [7:0] QSM_CMD    = 8'h10; // Command, write starts it
	localparam logic [7:0] QSM_STATUS = 8'h14; // Flags, write one to clear
	localparam logic [7:0] QSM_RES0   = 8'h20; // Result words 0..3
	localparam logic [7:0] QSM_ACC0   = 8'h30; // Accumulator bank words 0..3
	localparam logic [7:0] QSM_EXT    = 8'h40; // Accumulator extension word
	localparam logic [7:0] QSM_STRIDE = 8'h04; // Word spacing in arrays

	// Data shapes
	localparam int QSM_LANES   = 4;  // Lanes per instruction
	localparam int QSM_LANE_W  = 16; // Bits per short lane
	localparam int QSM_QEXT_W  = 8;  // Extension bits per lane, full quad
	localparam int QSM_PEXT_W  = 4;  // Extension bits per lane, pair
	localparam int QSM_PEXT_HI = 16; // Extension base for the upper pair
	localparam int QSM_CMD_W   = 10; // Command field width
	localparam int QSM_FLAGS_W = 6;  // Flag field width

	// Saturation and rounding constants
	localparam logic [15:0] QSM_S16_MAX   = 16'h7FFF;
	localparam logic [15:0] QSM_S16_MIN   = 16'h8000; // Also the most negative fraction
	localparam logic [15:0] QSM_U16_MAX   = 16'hFFFF;
	localparam logic [31:0] QSM_FRAC_MAX  = 32'h7FFFFFFF;
	localparam logic [32:0] QSM_ROUND_INC = 33'h000008000;

	// Accumulator limit exponents: signed range is -2^e..2^e-1, unsigned 0..2^e-1
	localparam logic [5:0] QSM_EXP_QUAD_SF = 6'h26; // 38
	localparam logic [5:0] QSM_EXP_QUAD_SI = 6'h27; // 39
	localparam logic [5:0] QSM_EXP_QUAD_U  = 6'h28; // 40
	localparam logic [5:0] QSM_EXP_PAIR_SF = 6'h12; // 18
	localparam logic [5:0] QSM_EXP_PAIR_SI = 6'h13; // 19
	localparam logic [5:0] QSM_EXP_PAIR_U  = 6'h14; // 20
	localparam logic [5:0] QSM_EXP_XQ_S    = 6'h1F; // 31, quad transfer
	localparam logic [5:0] QSM_EXP_XQ_U    = 6'h20; // 32
	localparam logic [5:0] QSM_EXP_XP_S    = 6'h0F; // 15, pair transfer
	localparam logic [5:0] QSM_EXP_XP_U    = 6'h10; // 16

	// Operation selects, command bits 1:0
	typedef enum logic [1:0] {
		QSM_OP_MUL_SHORT,
		QSM_OP_MUL_WORD,
		QSM_OP_MAC,
		QSM_OP_MAC_MOVE
	} qsm_op_type;

	// Accumulator selects, command bits 3:2; bit 1 set means full quad
	typedef enum logic [1:0] {
		QSM_ACC_PAIR_LO,
		QSM_ACC_PAIR_HI,
		QSM_ACC_QUAD,
		QSM_ACC_QUAD_ALT
	} qsm_acc_type;

	// Command word, low bit first: op, acc_sel, then the options
	typedef struct packed {
		logic        clear_round;
		logic        clear;
		logic        saturate;
		logic        truncate;
		logic        integer_mode;
		logic        unsigned_mode;
		qsm_acc_type acc_sel;
		qsm_op_type  op;
	} qsm_cmd_type;

	// Flag word, bit 5 first
	typedef struct packed {
		logic sticky_underflow_flag;
		logic underflow_flag;
		logic sticky_overflow_flag;
		logic overflow_flag;
		logic lane_negative_flag;
		logic lane_zero_flag;
	} qsm_flags_type;

	localparam logic [9:0] QSM_CMD_RESET   = 10'h000;
	localparam logic [5:0] QSM_FLAGS_RESET = 6'h00;

endpackage

`default_nettype wire

// ### verilog/qsm_core.sv
// Quad-short multiplier and multiply-accumulate datapath with APB registers.
// Assumes an APB master on pclk; operands and commands come from software.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Multiply four 16-bit lanes independently
// - Fractional short results rounded unless truncate
// - Default signed fractional; unsigned, integer options
// - Saturate option applies to integer only
// - Quad destination keeps four full 32-bit products
// - Zero flag when any lane result zero
// - Negative flag when any lane negative
// - Fraction/quad never overflow except most-negative squared
// - Signed integer overflow from upper 17 bits
// - Sticky follows overflow; underflow cleared, sticky kept
// - Accumulate lane products into same accumulator
// - Full quad: each lane own 32-bit word
// - Pair: two 16-bit lanes per word
// - Extension bits kept; accumulation always saturates
// - Full quad sticky limits per data type
// - Signed pair sticky limits, integer product check
// - Unsigned pair sticky limits, integer product check
// - Clear drops old value; clear-round also rounds
// - Sticky overflow held until software clears
// - Transfer saturates and sets sticky on extension
// - Four extension bits pair, eight quad
// - Accumulator transfer truncates, never rounds
module qsm_core (
	input  wire logic        pclk,    // APB clock
	input  wire logic        presetn, // Asynchronous reset, low active
	input  wire logic        psel,    // Slave select
	input  wire logic        penable, // Access phase
	input  wire logic        pwrite,  // Write direction
	input  wire logic [7:0]  paddr,   // Byte address
	input  wire logic [31:0] pwdata,  // Write data
	output logic      [31:0] prdata,  // Read data
	output logic             pready,  // Transfer done
	output logic             pslverr  // Unmapped address
);
	import qsm_pkg::*;

	// Software-visible state
	logic [31:0]   opa_lo;         // First operand low word
	logic [31:0]   opa_hi;         // First operand high word
	logic [31:0]   opb_lo;         // Second operand low word
	logic [31:0]   opb_hi;         // Second operand high word
	qsm_cmd_type   last_cmd;       // Last command accepted
	qsm_flags_type flags;          // Multiplier flags
	logic [31:0]   res [4];        // Result words
	logic [31:0]   accumulator_bank [4]; // Accumulator words
	logic [31:0]   accumulator_extension_word; // Overflow extension bits

	// Next values from the datapath
	logic [31:0]   next_res [4];
	logic [31:0]   next_acc [4];
	logic [31:0]   next_ext;
	qsm_flags_type next_flags;

	// Bus decode
	logic          access;         // Access phase seen
	logic          wr_en;          // Write takes effect now
	logic          exec;           // Command write takes effect now
	logic [31:0]   rd_value;       // Read mux output
	logic          mapped;         // Address decodes to a register

	// Datapath working values
	qsm_cmd_type        cmd;       // Command on the write bus
	logic [31:0]        opa;       // Unused name guard
	logic [63:0]        opa_q;     // Packed first operand
	logic [63:0]        opb_q;     // Packed second operand
	logic               sgn;       // Signed operands
	logic               quad;      // Full quad accumulator chosen
	logic               round_on;  // Rounding active for this op
	logic [1:0]         pbase;     // First word of chosen pair
	int                 epos;      // Extension base of chosen pair
	logic [15:0]        a;         // Lane of first operand
	logic [15:0]        b;         // Lane of second operand
	logic signed [33:0] px;        // Extended product
	logic [31:0]        full;      // Full 32-bit product
	logic [31:0]        fw;        // Fractional word product
	logic [32:0]        frnd;      // Rounded fractional product
	logic               mnf;       // Most negative fraction squared
	logic               iovf;      // Integer product overflow
	logic [15:0]        sh;        // Short lane result
	logic [31:0]        q32;       // Quad accumulator addend
	logic [15:0]        p16;       // Pair accumulator addend
	logic [39:0]        old40;     // Old quad lane value
	logic [19:0]        old20;     // Old pair lane value
	logic [1:0]         idx;       // Pair word index
	logic signed [43:0] old_v;     // Old lane value, extended
	logic signed [43:0] prod_v;    // Addend, extended
	logic signed [43:0] sum_v;     // Raw lane sum
	logic signed [43:0] sat_v;     // Saturated lane sum
	logic signed [43:0] xfer_v;    // Saturated transfer value
	logic [5:0]         e;         // Accumulation limit exponent
	logic [5:0]         xe;        // Transfer limit exponent
	logic               ov_s;      // Lane sum left its range
	logic               ov_x;      // Transfer value left its range
	logic               any_zero;  // Some lane result is zero
	logic               any_neg;   // Some lane result is negative
	logic               any_ovf;   // Some multiply overflowed
	logic               mac_ovf;   // Some accumulation overflowed

	// Address match, shared by read and write decode
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
		addr_is = (addr == off);
	endfunction

	// Clamp to -2^e..2^e-1 signed or 0..2^e-1 unsigned; top bit flags clamping
	function automatic logic [44:0] clamp(input logic signed [43:0] v,
		input logic [5:0] ex, input logic s);
		logic signed [43:0] lim;
		lim = 44'sd1 <<< ex;
		if (v >= lim) begin
			clamp = {1'b1, lim - 44'sd1};
		end else if (s ? (v < -lim) : (v < 44'sd0)) begin
			clamp = {1'b1, s ? -lim : 44'sd0};
		end else begin
			clamp = {1'b0, v};
		end
	endfunction

	// APB strobes
	assign access = psel & penable;
	assign wr_en  = access & pready & pwrite;
	assign exec   = wr_en & addr_is(paddr, QSM_CMD);
	assign opa    = 32'h0000_0000;

	// Address map check
	always_comb begin
		mapped = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (addr_is(paddr, 8'(QSM_RES0 + QSM_STRIDE * i))
				|| addr_is(paddr, 8'(QSM_ACC0 + QSM_STRIDE * i))) begin
				mapped = 1'b1;
			end
		end
		if (addr_is(paddr, QSM_OPA_LO) || addr_is(paddr, QSM_OPA_HI)
			|| addr_is(paddr, QSM_OPB_LO) || addr_is(paddr, QSM_OPB_HI)
			|| addr_is(paddr, QSM_CMD) || addr_is(paddr, QSM_STATUS)
			|| addr_is(paddr, QSM_EXT)) begin
			mapped = 1'b1;
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_value = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (addr_is(paddr, 8'(QSM_RES0 + QSM_STRIDE * i))) begin
				rd_value = res[i];
			end
			if (addr_is(paddr, 8'(QSM_ACC0 + QSM_STRIDE * i))) begin
				rd_value = accumulator_bank[i];
			end
		end
		if (addr_is(paddr, QSM_OPA_LO)) rd_value = opa_lo;
		if (addr_is(paddr, QSM_OPA_HI)) rd_value = opa_hi;
		if (addr_is(paddr, QSM_OPB_LO)) rd_value = opb_lo;
		if (addr_is(paddr, QSM_OPB_HI)) rd_value = opb_hi;
		if (addr_is(paddr, QSM_CMD)) rd_value = {22'h000000, last_cmd};
		if (addr_is(paddr, QSM_STATUS)) rd_value = {26'h0000000, flags};
		if (addr_is(paddr, QSM_EXT)) rd_value = accumulator_extension_word;
	end

	// Lane datapath: multiply, round, saturate, accumulate, transfer
	always_comb begin
		cmd      = qsm_cmd_type'(pwdata[QSM_CMD_W-1:0]);
		opa_q    = {opa_hi, opa_lo};
		opb_q    = {opb_hi, opb_lo};
		sgn      = ~cmd.unsigned_mode;
		quad     = cmd.acc_sel[1];
		round_on = (cmd.op == QSM_OP_MUL_SHORT) ? ~cmd.truncate : cmd.clear_round;
		pbase    = (cmd.acc_sel == QSM_ACC_PAIR_HI) ? 2'h2 : 2'h0;
		epos     = (cmd.acc_sel == QSM_ACC_PAIR_HI) ? QSM_PEXT_HI : 0;
		next_res = res;
		next_acc = accumulator_bank;
		next_ext = accumulator_extension_word;
		next_flags = flags;
		a = 16'h0000; b = 16'h0000; px = 34'sh0; full = 32'h0; fw = 32'h0;
		frnd = 33'h0; mnf = 1'b0; iovf = 1'b0; sh = 16'h0; q32 = 32'h0;
		p16 = 16'h0; old40 = 40'h0; old20 = 20'h0; idx = 2'h0;
		old_v = 44'sh0; prod_v = 44'sh0; sum_v = 44'sh0; sat_v = 44'sh0;
		xfer_v = 44'sh0; e = 6'h0; xe = 6'h0; ov_s = 1'b0; ov_x = 1'b0;
		any_zero = 1'b0; any_neg = 1'b0; any_ovf = 1'b0; mac_ovf = 1'b0;
		for (int k = 0; k < QSM_LANES; k++) begin
			// Lane operands and full product
			a    = opa_q[QSM_LANE_W*k +: QSM_LANE_W];
			b    = opb_q[QSM_LANE_W*k +: QSM_LANE_W];
			px   = $signed({sgn & a[15], a}) * $signed({sgn & b[15], b});
			full = px[31:0];
			mnf  = sgn & ~cmd.integer_mode & (a == QSM_S16_MIN) & (b == QSM_S16_MIN);
			// Fraction product aligned to a word; the one unrepresentable case clamps
			fw   = mnf ? QSM_FRAC_MAX : (sgn ? {full[30:0], 1'b0} : full);
			frnd = {1'b0, fw} + (round_on ? QSM_ROUND_INC : 33'h0);
			// Integer product range checks
			iovf = sgn ? ~((&full[31:15]) | ~(|full[31:15]))
				: (|full[31:16]);
			unique case (cmd.op)
				QSM_OP_MUL_SHORT: begin
					if (cmd.integer_mode) begin
						sh = full[15:0];
						if (cmd.saturate && iovf) begin
							sh = sgn ? (full[31] ? QSM_S16_MIN : QSM_S16_MAX) : QSM_U16_MAX;
						end
						any_ovf = any_ovf | iovf;
					end else begin
						sh = mnf ? QSM_S16_MAX : frnd[31:16];
					end
					any_ovf  = any_ovf | mnf;
					any_zero = any_zero | (sh == 16'h0000);
					any_neg  = any_neg | (sgn & sh[15]);
					next_res[k/2][QSM_LANE_W*(k%2) +: QSM_LANE_W] = sh;
				end
				QSM_OP_MUL_WORD: begin
					next_res[k] = cmd.integer_mode ? full : fw;
					any_ovf  = any_ovf | mnf;
					any_zero = any_zero | (next_res[k] == 32'h0000_0000);
					any_neg  = any_neg | (sgn & next_res[k][31]);
				end
				default: begin
					// Accumulate paths; both remaining op codes land here
					idx = pbase + 2'(k/2);
					if (quad) begin
						old40  = {accumulator_extension_word[QSM_QEXT_W*k +: QSM_QEXT_W],
							accumulator_bank[k]};
						old_v  = sgn ? {{4{old40[39]}}, old40} : {4'h0, old40};
						q32    = cmd.integer_mode ? full
							: ((cmd.clear_round && !mnf) ? {frnd[31:16], 16'h0000} : fw);
						prod_v = sgn ? {{12{q32[31]}}, q32} : {12'h000, q32};
						e  = cmd.integer_mode ? (sgn ? QSM_EXP_QUAD_SI : QSM_EXP_QUAD_U)
							: (sgn ? QSM_EXP_QUAD_SF : QSM_EXP_QUAD_U);
						xe = sgn ? QSM_EXP_XQ_S : QSM_EXP_XQ_U;
					end else begin
						old20  = {accumulator_extension_word[epos + QSM_PEXT_W*k +: QSM_PEXT_W],
							accumulator_bank[idx][QSM_LANE_W*(k%2) +: QSM_LANE_W]};
						old_v  = sgn ? {{24{old20[19]}}, old20} : {24'h000000, old20};
						if (cmd.integer_mode) begin
							// Intermediate product must fit a short
							p16 = iovf ? (sgn ? (full[31] ? QSM_S16_MIN : QSM_S16_MAX)
								: QSM_U16_MAX) : full[15:0];
							mac_ovf = mac_ovf | iovf;
						end else begin
							p16 = mnf ? QSM_S16_MAX : frnd[31:16];
						end
						prod_v = sgn ? {{28{p16[15]}}, p16} : {28'h0000000, p16};
						e  = cmd.integer_mode ? (sgn ? QSM_EXP_PAIR_SI : QSM_EXP_PAIR_U)
							: (sgn ? QSM_EXP_PAIR_SF : QSM_EXP_PAIR_U);
						xe = sgn ? QSM_EXP_XP_S : QSM_EXP_XP_U;
					end
					// Old value is dropped by either clear option
					sum_v = ((cmd.clear || cmd.clear_round) ? 44'sh0 : old_v) + prod_v;
					{ov_s, sat_v} = clamp(sum_v, e, sgn);
					mac_ovf = mac_ovf | ov_s;
					// Dual move: old contents go out first, clamped and truncated
					{ov_x, xfer_v} = clamp(old_v, xe, sgn);
					if (cmd.op == QSM_OP_MAC_MOVE) begin
						mac_ovf = mac_ovf | ov_x;
						if (quad) begin
							next_res[k] = xfer_v[31:0];
						end else begin
							next_res[k/2][QSM_LANE_W*(k%2) +: QSM_LANE_W] = xfer_v[15:0];
						end
					end
					// Write back into the same accumulator, extension bits included
					if (quad) begin
						next_acc[k] = sat_v[31:0];
						next_ext[QSM_QEXT_W*k +: QSM_QEXT_W] = sat_v[39:32];
					end else begin
						next_acc[idx][QSM_LANE_W*(k%2) +: QSM_LANE_W] = sat_v[15:0];
						next_ext[epos + QSM_PEXT_W*k +: QSM_PEXT_W] = sat_v[19:16];
					end
				end
			endcase
		end
		// Flag update per operation class
		if (cmd.op == QSM_OP_MUL_SHORT || cmd.op == QSM_OP_MUL_WORD) begin
			next_flags.lane_zero_flag     = any_zero;
			next_flags.lane_negative_flag = any_neg;
			next_flags.overflow_flag      = any_ovf;
			next_flags.sticky_overflow_flag = flags.sticky_overflow_flag | any_ovf;
			next_flags.underflow_flag     = 1'b0;
		end else begin
			next_flags.sticky_overflow_flag = flags.sticky_overflow_flag | mac_ovf;
		end
	end

	// APB answer: one wait state, then pready for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			if (access && !pready && !pwrite) begin
				prdata <= rd_value;
			end
		end
	end

	// Operand and command registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_lo   <= 32'h0000_0000;
			opa_hi   <= 32'h0000_0000;
			opb_lo   <= 32'h0000_0000;
			opb_hi   <= 32'h0000_0000;
			last_cmd <= qsm_cmd_type'(QSM_CMD_RESET);
		end else if (wr_en) begin
			if (addr_is(paddr, QSM_OPA_LO)) opa_lo <= pwdata;
			if (addr_is(paddr, QSM_OPA_HI)) opa_hi <= pwdata;
			if (addr_is(paddr, QSM_OPB_LO)) opb_lo <= pwdata;
			if (addr_is(paddr, QSM_OPB_HI)) opb_hi <= pwdata;
			if (exec) last_cmd <= cmd;
		end
	end

	// Result words, written only by a command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				res[i] <= 32'h0000_0000;
			end
		end else if (exec) begin
			res <= next_res;
		end
	end

	// Accumulator bank and extension word; command wins over a direct write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				accumulator_bank[i] <= 32'h0000_0000;
			end
			accumulator_extension_word <= 32'h0000_0000;
		end else if (exec) begin
			accumulator_bank           <= next_acc;
			accumulator_extension_word <= next_ext;
		end else if (wr_en) begin
			for (int i = 0; i < 4; i++) begin
				if (addr_is(paddr, 8'(QSM_ACC0 + QSM_STRIDE * i))) begin
					accumulator_bank[i] <= pwdata;
				end
			end
			if (addr_is(paddr, QSM_EXT)) accumulator_extension_word <= pwdata;
		end
	end

	// Flags: updated by commands, sticky bits cleared only by software write-one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= qsm_flags_type'(QSM_FLAGS_RESET);
		end else if (exec) begin
			flags <= next_flags;
		end else if (wr_en && addr_is(paddr, QSM_STATUS)) begin
			flags <= flags & ~qsm_flags_type'(pwdata[QSM_FLAGS_W-1:0]);
		end
	end

endmodule // qsm_core

`default_nettype wire

// ### verif/qsm_core_props.sv
// Bus timing and flag checks for the quad multiply datapath.
// Assumes the APB port list of qsm_core; bound after the module.
`timescale 1ns/1ns
`default_nettype none
module qsm_core_props import qsm_pkg::*; (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic mapped;      // Address hits a register
	logic stat_rd;     // Status read completing
	logic sticky_seen; // Sticky seen set, not yet cleared
	assign mapped = paddr[1:0] == 2'b00 && (paddr <= QSM_STATUS
		|| (paddr >= QSM_RES0 && paddr <= QSM_EXT));
	assign stat_rd = pready && !pwrite && paddr == QSM_STATUS;
	// Track sticky overflow between software clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_seen <= 1'b0;
		end else if (pready && pwrite && paddr == QSM_STATUS && pwdata[3]) begin
			sticky_seen <= 1'b0;
		end else if (stat_rd && prdata[3]) begin
			sticky_seen <= 1'b1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(pready) || (pready && !pwrite))
		else $error("prdata moved outside a read");
	a_status_quiet: assert property (stat_rd |-> prdata[31:4] == 28'h0)
		else $error("underflow or unused status bits set");
	a_sticky_held: assert property (stat_rd && sticky_seen |-> prdata[3])
		else $error("sticky overflow lost without a clear");
endmodule // qsm_core_props
bind qsm_core qsm_core_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### verif/qsm_apb_master.sv
// Bus master standing in for the instruction sequencer.
// Assumes one APB slave on pclk; the bench calls its task.
`timescale 1ns/1ns
`default_nettype none
module qsm_apb_master (
	input  wire logic        pclk,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Setup, access, hold until pready, then release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data no longer valid
	endtask
endmodule // qsm_apb_master
`default_nettype wire

// ### verif/test_quad_short_multiply_accumulate.sv
// Self-checking bench for the quad multiply datapath.
// Assumes qsm_core, its bound checker and the bus master model.
`timescale 1ns/1ns
`default_nettype none
module test_quad_short_multiply_accumulate;
	import qsm_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, er, o, z, n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [15:0] a [4], b [4], r [4]; // Operands, short results
	longint      p [4], acc [4], f;   // Model products, accumulators
	int          miscompares = 0, comparisons = 0, cyc = 0;
	int          seed = 32'h5b7c;
	localparam logic [7:0] RA [5] = '{QSM_CMD, QSM_STATUS, QSM_RES0, QSM_ACC0, QSM_EXT};
	always #10 pclk = ~pclk;
	qsm_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	qsm_apb_master mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	task automatic wrap_up();
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic e;
		mst.xfer(1'b1, ad, d, rv, e);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		logic e;
		mst.xfer(1'b0, ad, 32'h0, d, e);
	endtask
	task automatic rnd();
		foreach (a[k]) begin
			a[k] = 16'($random(seed));
			b[k] = 16'($random(seed));
		end
	endtask
	// Load operands, issue a command, model the lane products
	task automatic run(input logic [9:0] c);
		wr(QSM_OPA_LO, {a[1], a[0]});
		wr(QSM_OPA_HI, {a[3], a[2]});
		wr(QSM_OPB_LO, {b[1], b[0]});
		wr(QSM_OPB_HI, {b[3], b[2]});
		wr(QSM_CMD, {22'h0, c});
		foreach (p[k]) p[k] = c[4] ? longint'(a[k]) * longint'(b[k])
			: longint'($signed(a[k])) * longint'($signed(b[k]));
	endtask
	// Four words against the model accumulators
	task automatic words(input logic [7:0] base);
		for (int k = 0; k < 4; k++) begin
			rd(base + 8'(4 * k), rv);
			check("word", rv, acc[k][31:0]);
		end
	endtask
	task automatic shorts(input logic ov);
		rd(QSM_RES0, rv);
		check("short lo", rv, {r[1], r[0]});
		rd(QSM_RES0 + QSM_STRIDE, rv);
		check("short hi", rv, {r[3], r[2]});
		rd(QSM_STATUS, rv);
		check("ovf", {31'h0, rv[2]}, {31'h0, ov});
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(RA[i], rv);
			check("reset", rv, 32'h0);
		end
		mst.xfer(1'b0, 8'h18, 32'h0, rv, er);
		check("unmapped", {rv[30:0], er}, 32'h1);
		wr(QSM_RES0, 32'hFFFF_FFFF);
		rd(QSM_RES0, rv);
		check("res ro", rv, 32'h0);
		// Word results, signed and unsigned integer
		for (int i = 0; i < 6; i++) begin
			rnd();
			if (i == 0) b[2] = 16'h0000;
			run(i[0] ? 10'h031 : 10'h021);
			z = 1'b0;
			n = 1'b0;
			foreach (p[k]) begin
				acc[k] = p[k];
				z |= p[k] == 0;
				n |= p[k] < 0;
			end
			words(QSM_RES0);
			rd(QSM_STATUS, rv);
			if (!i[0]) check("flags", {29'h0, rv[2:0]}, {29'h0, 1'b0, n, z});
		end
		// Short integer, all signedness and saturate mixes
		for (int m = 0; m < 4; m++) begin
			rnd();
			a[0] &= 16'h007F;
			b[0] &= 16'h007F;
			run({2'b00, m[1], 2'b01, m[0], 4'h0});
			o = 1'b0;
			for (int k = 0; k < 4; k++) begin
				z = m[0] ? (p[k] > 65535) : (p[k] > 32767 || p[k] < -32768);
				o |= z;
				r[k] = !(z && m[1]) ? p[k][15:0] : m[0] ? QSM_U16_MAX
					: p[k] < 0 ? QSM_S16_MIN : QSM_S16_MAX;
			end
			shorts(o);
		end
		// Fraction, rounded then truncated, saturate ignored
		for (int t = 0; t < 2; t++) begin
			rnd();
			a[3] = QSM_S16_MIN;
			b[3] = QSM_S16_MIN;
			run({3'b001, t[0], 6'h00});
			for (int k = 0; k < 3; k++) begin
				f = 2 * p[k] + (t ? 0 : 32768);
				r[k] = f[31:16];
			end
			r[3] = QSM_S16_MAX;
			shorts(1'b1);
			// Clear-and-round into the full quad: rounded upper half only
			if (!t) begin
				run(10'h20A);
				foreach (r[k]) acc[k] = {r[k], 16'h0000};
				acc[3] = QSM_FRAC_MAX;
				words(QSM_ACC0);
			end
		end
		// Quiet multiply keeps sticky; software clears it
		a = '{16'h0003, 16'h0005, 16'h0007, 16'h0002};
		b = a;
		run(10'h021);
		rd(QSM_STATUS, rv);
		check("sticky kept", {30'h0, rv[3:2]}, 32'h2);
		wr(QSM_STATUS, 32'h0000_0008);
		rd(QSM_STATUS, rv);
		check("sticky clr", {31'h0, rv[3]}, 32'h0);
		// Full quad accumulate: clear, add, add with move
		for (int k = 0; k < 4; k++) wr(QSM_ACC0 + 8'(4 * k), 32'($random(seed)));
		rnd();
		foreach (b[k]) b[k] &= 16'h00FF;
		run(10'h12A);
		foreach (p[k]) acc[k] = p[k];
		words(QSM_ACC0);
		run(10'h02A);
		foreach (p[k]) acc[k] += p[k];
		words(QSM_ACC0);
		run(10'h02B);
		words(QSM_RES0);
		foreach (p[k]) acc[k] += p[k];
		words(QSM_ACC0);
		rd(QSM_EXT, rv);
		check("ext", rv, {acc[3][39:32], acc[2][39:32], acc[1][39:32], acc[0][39:32]});
		// Transfer clamps an old value whose extension bits are live
		for (int k = 0; k < 4; k++) wr(QSM_ACC0 + 8'(4 * k), 32'h0);
		wr(QSM_EXT, 32'h0000_0001);
		run(10'h02B);
		acc = '{32'h7FFF_FFFF, 0, 0, 0};
		words(QSM_RES0);
		rd(QSM_STATUS, rv);
		check("move sticky", {31'h0, rv[3]}, 32'h1);
		wr(QSM_STATUS, 32'h0000_0008);
		foreach (p[k]) acc[k] = p[k];
		// Pair accumulate, upper words, small signed integers
		foreach (a[k]) a[k] &= 16'h007F;
		run(10'h126);
		rd(QSM_ACC0 + 8'h08, rv);
		check("pair lo", rv, {p[1][15:0], p[0][15:0]});
		rd(QSM_ACC0 + 8'h0C, rv);
		check("pair hi", rv, {p[3][15:0], p[2][15:0]});
		rd(QSM_ACC0, rv);
		check("pair keep", rv, acc[0][31:0]);
		// Unsigned pair with products too wide for 16 bits
		a = '{default: 16'h0100};
		b = a;
		run(10'h132);
		rd(QSM_ACC0, rv);
		check("pair sat", rv, 32'hFFFF_FFFF);
		rd(QSM_STATUS, rv);
		check("pair sticky", {31'h0, rv[3]}, 32'h1);
		wrap_up();
	end
endmodule // test_quad_short_multiply_accumulate
`default_nettype wire
